// ---- design/ipd_ctrl.sv ----
// idle and power-down mode controller with its register and event flags
// assumes the cpu, clock tree and interrupt logic honour the enables it drives
`timescale 1ns/1ns
`default_nettype none

module ipd_ctrl
  import ipd_pkg::*;
#(
  parameter int EXT_W = IPD_EXT_W,
  parameter int KBI_W = IPD_KBI_W
)
(
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // wake and reset sources
  input wire logic [EXT_W-1:0] i_ext_int_n,
  input wire logic [EXT_W-1:0] i_ext_en,
  input wire logic i_global_int_enable,
  input wire logic [KBI_W-1:0] i_keypad_pin,
  input wire logic [KBI_W-1:0] i_keypad_en,
  input wire logic i_irq_req,
  input wire logic i_bod_irq,
  input wire logic i_wdt_irq,
  input wire logic i_bod_det_en,
  input wire logic i_bod_rst,
  input wire logic i_hw_rst,
  input wire logic i_cold_rst,
  input wire logic i_por_done,
  // clock and cpu control
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_osc_stop,
  output logic o_pc_hold,
  output logic o_port_hold,
  output logic o_wdt_clr,
  output logic o_cpu_reinit,
  output ipd_wake_t o_wake_src,
  output logic o_baud_doubler,
  output logic o_framing_error_select,
  output logic o_irq
);

  // ****************************************
  // wake pin synchronisers
  // ****************************************
  localparam int SW = EXT_W + KBI_W;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_stable;
  assign pin_raw = {i_keypad_pin, i_ext_int_n};

  // three sampling flops and a held-level flop per pin, a change counts once the last two samples agree
  for (genvar g = 0; g < SW; g++)
  begin : g_sync
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic st_ff;
    always_ff @(posedge i_ref_clk)
    begin
      if (!i_rst_n)
      begin
        s1_ff <= 1'b1;
        s2_ff <= 1'b1;
        s3_ff <= 1'b1;
        st_ff <= 1'b1;
      end
      else if (i_ce)
      begin
        s1_ff <= pin_raw[g];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff)
          st_ff <= s3_ff;
      end
    end
    assign pin_stable[g] = st_ff;
  end

  logic [EXT_W-1:0] ext_n;
  logic [KBI_W-1:0] kbi_lvl;
  assign ext_n = pin_stable[EXT_W-1:0];
  assign kbi_lvl = pin_stable[SW-1:EXT_W];

  // ****************************************
  // state
  // ****************************************
  ipd_mode_t mode_ff, nxt_mode;
  ipd_power_mode_control_t power_mode_control_ff, nxt_power_mode_control;
  ipd_ev_t ist_ff, nxt_ist;
  ipd_ev_t imsk_ff;
  ipd_wake_t wake_ff, nxt_wake;
  logic [KBI_W-1:0] kbi_ref_ff;
  logic bod_armed_ff;
  logic wdt_clr_ff, nxt_wdt_clr;
  logic reinit_ff;
  logic [7:0] rdata_ff, nxt_rdata;

  // ****************************************
  // register decode
  // ****************************************
  wire power_mode_control_sel = i_addr == IPD_POWER_MODE_CONTROL_ADDR;
  wire ist_sel = i_addr == IPD_IST_ADDR;
  wire imsk_sel = i_addr == IPD_IMSK_ADDR;
  wire power_mode_control_wr = i_wr && power_mode_control_sel;
  wire imsk_wr = i_wr && imsk_sel;
  wire ist_rd = i_rd && ist_sel;
  ipd_power_mode_control_t wr_power_mode_control;
  assign wr_power_mode_control = ipd_power_mode_control_t'(i_wdata);

  // control writes only land while the cpu runs; in a stopped mode it cannot issue them
  wire run = mode_ff == IPD_RUN;
  wire enter_pd = run && power_mode_control_wr && wr_power_mode_control.powerdown_request;
  wire enter_idle = run && power_mode_control_wr && wr_power_mode_control.idle_request && !enter_pd;

  // ****************************************
  // wake decode
  // ****************************************
  // an external pin needs its own enable and the global enable
  wire [EXT_W-1:0] ext_wake = ~ext_n & i_ext_en & {EXT_W{i_global_int_enable}};
  // keypad wakes only on a move away from the level held at entry
  wire [KBI_W-1:0] kbi_move = (kbi_lvl ^ kbi_ref_ff) & i_keypad_en;
  wire kbi_wake = |kbi_move;
  wire pd_wake = (|ext_wake) || i_bod_irq || i_wdt_irq || kbi_wake;
  // brown-out reset counts only if detection was on before entry
  wire pd_rst = i_hw_rst || (i_bod_rst && bod_armed_ff);
  wire in_idle = mode_ff == IPD_IDLE;
  wire in_pd = mode_ff == IPD_PDOWN;
  wire idle_exit = in_idle && (i_irq_req || i_hw_rst);
  wire pd_exit = in_pd && (pd_wake || pd_rst);

  // ****************************************
  // mode sequencing
  // ****************************************
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_wake = wake_ff;
    nxt_wdt_clr = 1'b0;
    unique case (mode_ff)
      IPD_RUN:
      begin
        if (enter_pd)
          nxt_mode = IPD_PDOWN;
        else if (enter_idle)
          nxt_mode = IPD_IDLE;
        nxt_wdt_clr = enter_pd || enter_idle;
      end
      IPD_IDLE:
      begin
        if (idle_exit)
        begin
          nxt_mode = IPD_RUN;
          nxt_wake = '0;
          nxt_wake.irq = i_irq_req;
          nxt_wdt_clr = 1'b1;
        end
      end
      IPD_PDOWN:
      begin
        if (pd_exit)
        begin
          nxt_mode = IPD_RUN; // never falls into idle
          nxt_wake.ext = ext_wake;
          nxt_wake.brownout_detector = i_bod_irq;
          nxt_wake.wdt = i_wdt_irq;
          nxt_wake.keypad_interrupt = kbi_wake;
          nxt_wake.irq = 1'b0;
          nxt_wdt_clr = 1'b1;
        end
      end
      default:
        nxt_mode = IPD_RUN;
    endcase
  end

  // ****************************************
  // power control register
  // ****************************************
  always_comb
  begin
    nxt_power_mode_control = power_mode_control_ff;
    if (power_mode_control_wr && run)
      nxt_power_mode_control = wr_power_mode_control;
    if (idle_exit)
      nxt_power_mode_control.idle_request = 1'b0;
    if (pd_exit)
    begin
      nxt_power_mode_control.powerdown_request = 1'b0;
      nxt_power_mode_control.idle_request = 1'b0;
    end
    // detection completing beats a clearing write in the same cycle
    if (i_por_done)
      nxt_power_mode_control.power_on_flag = 1'b1;
    nxt_power_mode_control.unused = 1'b0;
  end

  // ****************************************
  // event flags: set wins over clear-on-read
  // ****************************************
  always_comb
  begin
    nxt_ist = ist_rd ? ipd_ev_t'(IPD_ZERO8) : ist_ff;
    nxt_ist.idle_entry = nxt_ist.idle_entry | enter_idle;
    nxt_ist.pd_entry = nxt_ist.pd_entry | enter_pd;
    nxt_ist.idle_wake = nxt_ist.idle_wake | idle_exit;
    nxt_ist.pd_wake = nxt_ist.pd_wake | pd_exit;
  end

  // read mux, unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = IPD_ZERO8;
    if (i_rd && power_mode_control_sel)
      nxt_rdata = power_mode_control_ff;
    else if (ist_rd)
      nxt_rdata = ist_ff;
    else if (i_rd && imsk_sel)
      nxt_rdata = imsk_ff;
  end

  // ****************************************
  // flops
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      mode_ff <= IPD_RUN;
      power_mode_control_ff <= ipd_power_mode_control_t'(IPD_POWER_MODE_CONTROL_RST);
      ist_ff <= ipd_ev_t'(IPD_ZERO8);
      imsk_ff <= ipd_ev_t'(IPD_ZERO8);
      wake_ff <= '0;
      wdt_clr_ff <= 1'b0;
      reinit_ff <= 1'b0;
      rdata_ff <= IPD_ZERO8;
    end
    else if (i_ce)
    begin
      mode_ff <= nxt_mode;
      power_mode_control_ff <= nxt_power_mode_control;
      ist_ff <= nxt_ist;
      wake_ff <= nxt_wake;
      wdt_clr_ff <= nxt_wdt_clr;
      reinit_ff <= in_pd && i_cold_rst;
      rdata_ff <= nxt_rdata;
      if (imsk_wr)
        imsk_ff <= ipd_ev_t'({4'h0, i_wdata[3:0]});
    end
  end

  // entry snapshot of keypad levels and brown-out enable
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      kbi_ref_ff <= '1;
      bod_armed_ff <= 1'b0;
    end
    else if (i_ce && enter_pd)
    begin
      kbi_ref_ff <= kbi_lvl;
      bod_armed_ff <= i_bod_det_en;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // idle keeps peripherals clocked; power-down stops the whole tree
  assign o_cpu_clk_en = run;
  assign o_periph_clk_en = !in_pd;
  assign o_osc_stop = in_pd;
  assign o_pc_hold = !run;
  assign o_port_hold = !run;
  assign o_wdt_clr = wdt_clr_ff;
  assign o_cpu_reinit = reinit_ff;
  assign o_wake_src = wake_ff;
  assign o_baud_doubler = power_mode_control_ff.baud_doubler;
  assign o_framing_error_select = power_mode_control_ff.framing_error_select;
  assign o_irq = |(ist_ff & imsk_ff);
  assign o_rdata = rdata_ff;

  // ****************************************
  // checks
  // ****************************************
  pd_priority_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ce && run && power_mode_control_wr && i_wdata[1] && i_wdata[0] |=> mode_ff == IPD_PDOWN)
    else $error("both requests did not enter power-down");

  pd_clocks_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    in_pd |-> !o_cpu_clk_en && !o_periph_clk_en && o_pc_hold && o_osc_stop)
    else $error("clocks running in power-down");

  idle_clocks_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    in_idle |-> !o_cpu_clk_en && o_periph_clk_en && o_port_hold)
    else $error("idle clock gating wrong");

  idle_entry_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ce && run && power_mode_control_wr && i_wdata[1:0] == 2'b01 |=> in_idle ##0 o_wdt_clr)
    else $error("idle not entered after write");

  idle_exit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ce && in_idle && i_irq_req |=> run && !power_mode_control_ff.idle_request && o_wdt_clr)
    else $error("idle not ended by interrupt");

  pd_wake_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ce && in_pd && pd_wake |=> run && !power_mode_control_ff.powerdown_request && !power_mode_control_ff.idle_request)
    else $error("power-down wake did not clear request");

  pd_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ce && in_pd && !pd_wake && !pd_rst |=> in_pd && !o_wdt_clr)
    else $error("power-down left without a cause");

  hw_rst_exit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ce && !run && i_hw_rst |=> run ##1 !o_wdt_clr)
    else $error("hardware reset did not end low-power mode");

  cold_init_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ce && in_pd && i_cold_rst |=> o_cpu_reinit && run)
    else $error("cold reset did not reinitialise cpu");

  pof_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ce && i_por_done |=> power_mode_control_ff.power_on_flag)
    else $error("power-on flag not set");

endmodule // ipd_ctrl

`default_nettype wire

// ---- common/ipd_pkg.sv ----
// package for the idle / power-down controller
// assumes one system clock and a byte-wide register port
package ipd_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] IPD_POWER_MODE_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] IPD_IST_ADDR = 8'ha8;
  localparam logic [7:0] IPD_IMSK_ADDR = 8'ha9;
  localparam logic [7:0] IPD_POWER_MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] IPD_ZERO8 = 8'h00;

  // ****************************************
  // widths
  // ****************************************
  localparam int IPD_EXT_W = 2;
  localparam int IPD_KBI_W = 8;

  // power_mode_control layout, msb first
  typedef struct packed {
    logic baud_doubler;
    logic framing_error_select;
    logic unused;
    logic power_on_flag;
    logic general_flag_high;
    logic general_flag_low;
    logic powerdown_request;
    logic idle_request;
  } ipd_power_mode_control_t;

  // event status / mask layout
  typedef struct packed {
    logic [3:0] zero;
    logic pd_wake;
    logic idle_wake;
    logic pd_entry;
    logic idle_entry;
  } ipd_ev_t;

  // source that ended power-down or idle
  typedef struct packed {
    logic [IPD_EXT_W-1:0] ext;
    logic brownout_detector;
    logic wdt;
    logic keypad_interrupt;
    logic irq;
  } ipd_wake_t;

  typedef enum logic [1:0] {
    IPD_RUN = 2'b00,
    IPD_IDLE = 2'b01,
    IPD_PDOWN = 2'b10
  } ipd_mode_t;

endpackage

// ---- testbench/ipd_src_model.sv ----
// wake sources outside the power-mode controller: external and keypad pins
// assumes the bench calls its tasks; released pins sit at their pulled-up level
`timescale 1ns/1ns
`default_nettype none
module ipd_src_model
(
  // clock
  input wire logic i_ref_clk,
  // source pins
  output logic [1:0] o_ext_int_n,
  output logic [7:0] o_keypad_pin
);
  // ****************************************
  // pin drivers
  // ****************************************
  // pins start released; active-low lines rest high
  initial o_ext_int_n = 2'b11;
  initial o_keypad_pin = 8'hff;
  // levels change just after an edge, never in the sampling step
  task automatic set_ext(input int n, input logic v);
    @(posedge i_ref_clk);
    o_ext_int_n[n] <= v;
  endtask
  task automatic set_key(input logic [7:0] v);
    @(posedge i_ref_clk);
    o_keypad_pin <= v;
  endtask
endmodule // ipd_src_model
`default_nettype wire

// ---- testbench/idle_powerdown_controller_bench.sv ----
// self-checking bench for the idle / power-down controller
// assumes ipd_pkg and a source model driving the wake pins
`timescale 1ns/1ns
`default_nettype none
module idle_powerdown_controller_bench
  import ipd_pkg::*;
;
  logic i_ref_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, gie = 1, irq_req = 0;
  logic wdt_irq = 0, bod_en = 0, bod_rst = 0, hw_rst = 0, cold_rst = 0, por_done = 0;
  logic bod_irq = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, key_en = 0, o_rdata, key, d;
  logic [1:0] ext_n;
  logic cpu_en, per_en, osc, pch, prh, wclr, reinit, baud, fes, irq;
  ipd_wake_t wsrc;
  int m_mode = 0, m_power_mode_control = 0, m_stat = 0, m_mask = 0, n_errors = 0, total_checks = 0;
  int seed = 67679;
  ipd_ctrl ipd_ctrl_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ext_int_n(ext_n), .i_ext_en(2'b11), .i_global_int_enable(gie), .i_keypad_pin(key),
    .i_keypad_en(key_en), .i_irq_req(irq_req), .i_bod_irq(bod_irq), .i_wdt_irq(wdt_irq),
    .i_bod_det_en(bod_en), .i_bod_rst(bod_rst), .i_hw_rst(hw_rst), .i_cold_rst(cold_rst),
    .i_por_done(por_done), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
    .o_osc_stop(osc), .o_pc_hold(pch), .o_port_hold(prh), .o_wdt_clr(wclr),
    .o_cpu_reinit(reinit), .o_wake_src(wsrc), .o_baud_doubler(baud),
    .o_framing_error_select(fes), .o_irq(irq));
  ipd_src_model ipd_src_model_inst (.i_ref_clk(i_ref_clk), .o_ext_int_n(ext_n),
    .o_keypad_pin(key));
  always #4 i_ref_clk = ~i_ref_clk;
  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // clock gating outputs follow the modelled mode; irq follows status and mask
  task automatic chk_mode;
    chk({2'b00, cpu_en, per_en, osc, pch, prh, irq}, {2'b00, m_mode == 0, m_mode != 2,
      m_mode == 2, m_mode != 0, m_mode != 0, (m_stat & m_mask) != 0}, "mode");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
    if (a == IPD_IMSK_ADDR)
      m_mask = v & 8'h0f;
    // control writes count only while running
    if (a == IPD_POWER_MODE_CONTROL_ADDR && m_mode == 0)
    begin
      m_power_mode_control = v & 8'hdf;
      if (v[1:0] != 2'b00)
      begin
        m_mode = v[1] ? 2 : 1;
        m_stat |= v[1] ? 2 : 1;
        chk({7'h00, wclr}, 8'h01, "entry wdt clear");
      end
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input int exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp[7:0], "rdata");
    if (a == IPD_IST_ADDR)
      m_stat = 0;
  endtask
  // bounded wait for the cpu to run again
  task automatic wait_run;
    for (int i = 0; i < 12 && pch !== 1'b0; i++)
    begin
      @(posedge i_ref_clk);
      #1;
    end
    // every exit, reset-type ones too, raises the matching wake flag
    m_stat |= (m_mode == 2) ? 8 : 4;
    m_mode = 0;
    chk({7'h00, wclr}, 8'h01, "wake wdt clear");
  endtask
  task automatic wake(input int pd, input logic [7:0] src);
    wait_run();
    m_power_mode_control &= 8'hfc;
    chk_mode();
    chk({2'b00, wsrc}, src, "wake source");
    rdchk(IPD_POWER_MODE_CONTROL_ADDR, m_power_mode_control);
  endtask
  // after a reset-type exit the flags are cleared by software
  task automatic resync;
    rdchk(IPD_IST_ADDR, m_stat);
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h00);
    chk_mode();
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rdchk(IPD_POWER_MODE_CONTROL_ADDR, 0);
    chk_mode();
    wr(8'h10, 8'hff);
    rdchk(8'h10, 0);
    wr(IPD_IMSK_ADDR, 8'hff);
    rdchk(IPD_IMSK_ADDR, 8'h0f);
    repeat (4)
    begin
      d = $random(seed) & 8'hfc;
      wr(IPD_POWER_MODE_CONTROL_ADDR, d);
      rdchk(IPD_POWER_MODE_CONTROL_ADDR, m_power_mode_control);
      chk({6'h00, baud, fes}, {6'h00, d[7:6]}, "serial bits");
    end
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h01);
    chk_mode();
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h02);
    chk_mode();
    irq_req <= 1'b1;
    wake(0, 8'h01);
    irq_req <= 1'b0;
    rdchk(IPD_IST_ADDR, m_stat);
    gie <= 1'b0;
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h03);
    chk_mode();
    ipd_src_model_inst.set_ext(0, 1'b0);
    repeat (8) @(posedge i_ref_clk);
    #1;
    chk_mode();
    gie <= 1'b1;
    wake(1, 8'h10);
    ipd_src_model_inst.set_ext(0, 1'b1);
    // let the released pin pass the synchroniser before the next entry
    repeat (4) @(posedge i_ref_clk);
    key_en <= 8'h01;
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h02);
    bod_rst <= 1'b1;
    @(posedge i_ref_clk);
    bod_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1;
    chk_mode();
    ipd_src_model_inst.set_key(8'hfe);
    wake(1, 8'h02);
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h02);
    ipd_src_model_inst.set_key(8'hff);
    wake(1, 8'h02);
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h02);
    wdt_irq <= 1'b1;
    wake(1, 8'h04);
    wdt_irq <= 1'b0;
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h02);
    bod_irq <= 1'b1;
    wake(1, 8'h08);
    bod_irq <= 1'b0;
    bod_en <= 1'b1;
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h02);
    bod_en <= 1'b0;
    bod_rst <= 1'b1;
    wait_run();
    bod_rst <= 1'b0;
    resync();
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h02);
    hw_rst <= 1'b1;
    cold_rst <= 1'b1;
    wait_run();
    chk({7'h00, reinit}, 8'h01, "reinit");
    hw_rst <= 1'b0;
    cold_rst <= 1'b0;
    resync();
    wr(IPD_IMSK_ADDR, 8'h02);
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h01);
    chk_mode();
    hw_rst <= 1'b1;
    wait_run();
    hw_rst <= 1'b0;
    resync();
    por_done <= 1'b1;
    @(posedge i_ref_clk);
    por_done <= 1'b0;
    rdchk(IPD_POWER_MODE_CONTROL_ADDR, 8'h10);
    wr(IPD_POWER_MODE_CONTROL_ADDR, 8'h00);
    rdchk(IPD_POWER_MODE_CONTROL_ADDR, 8'h00);
    report_and_stop();
  end
endmodule // idle_powerdown_controller_bench
`default_nettype wire
